/* File: logic/fpt_defs.svh */
// Constants of the fan PWM and tachometer controller: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef FPT_DEFS_SVH
`define FPT_DEFS_SVH
`define FPT_NUM_FANS      4
`define FPT_CLK_HZ        10000000
`define FPT_PWM_FREQ_HZ   18
`define FPT_DUTY_STEPS    100
`define FPT_DUTY_FULL     7'h64
`define FPT_WINDOW_MS     125
`define FPT_STAGGER_MS    500
`define FPT_TICK_DIV      5'h1F
`define FPT_OFS_CTRL      8'h00
`define FPT_OFS_POWER0    8'h04
`define FPT_OFS_FSTIME    8'h14
`define FPT_OFS_GLITCH    8'h18
`define FPT_OFS_INTSTAT   8'h1C
`define FPT_OFS_INTMASK   8'h20
`define FPT_OFS_RESULT0   8'h24
`define FPT_OFS_STATUS    8'h34
`define FPT_CTRL_REP_LSB  0
`define FPT_CTRL_FS_LSB   4
`define FPT_INT_FS_BIT    4
`define FPT_RST_CTRL      8'h00
`define FPT_RST_FSTIME    8'h10
`define FPT_RST_GLITCH    8'h01
`define FPT_RST_INTMASK   5'h00
`endif

/* File: logic/fpt_pkg.sv */
// Types shared by the fan PWM and tachometer controller modules.
// Assumes the constants header is on the include path.
`include "fpt_defs.svh"
package fpt_pkg;
  typedef enum logic [1:0] {FPT_LOAD, FPT_STAGGER, FPT_RUN} fpt_seq_t;
  typedef struct packed {
    logic gate;
  } fpt_chan_state_t;
  typedef struct packed {
    logic        active;
    logic        stretch;
    logic        primed;
    logic        prevTach;
    logic [7:0]  glCnt;
    logic [7:0]  edges;
    logic        running;
    logic [4:0]  div;
    logic [15:0] tRun;
    logic [15:0] ticks;
  } fpt_tach_state_t;
  typedef struct packed {
    logic [3:0]       ctrlRep;
    logic [3:0]       ctrlFs;
    logic [3:0][6:0]  power;
    logic [7:0]       fsTime;
    logic [7:0]       glitch;
    logic [4:0]       intStat;
    logic [4:0]       intMask;
    logic [3:0][23:0] result;
    logic [31:0]      rdata;
    fpt_seq_t         seq;
    logic [1:0]       startIdx;
    logic [3:0]       started;
    logic [22:0]      gapCnt;
    logic [12:0]      stepCnt;
    logic [6:0]       phase;
    logic [20:0]      winCnt;
    logic [1:0]       measFan;
    logic [7:0]       fsCnt;
    logic [31:0]      byteSh;
    logic [2:0]       byteCnt;
    logic [7:0]       byteOut;
    logic             byteValid;
    logic             byteFirst;
  } fpt_top_state_t;
endpackage

/* File: logic/fpt_pwm_chan.sv */
// One fan channel: compares the shared duty phase with the channel duty.
// Assumes phase runs 0 to 99 once per PWM period and force_on comes from the tach logic.
`timescale 1ns/1ns
`default_nettype none
module fpt_pwm_chan
  import fpt_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       ce,
  input  wire logic [6:0] duty,
  input  wire logic [6:0] phase,
  input  wire logic       force_on,
  output logic            gateOn
);
  fpt_chan_state_t s_reg;
  fpt_chan_state_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.gate = force_on || (phase < duty);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign gateOn = s_reg.gate;

  property p_zero_off;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && duty == 7'h00 && !force_on |=> !gateOn;
  endproperty
  a_zero_off: assert property (p_zero_off) else $error("Zero duty left the gate on.");

  property p_force_on;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && force_on |=> gateOn;
  endproperty
  a_force_on: assert property (p_force_on) else $error("Forced fan not switched on.");
endmodule
`default_nettype wire

/* File: logic/fpt_tach_meas.sv */
// Tach measurement for the fan under test: stretch control, edge and tick counting.
// Assumes start and winEnd pulse on the same window boundary and tach is synchronous.
`timescale 1ns/1ns
`default_nettype none
`include "fpt_defs.svh"
module fpt_tach_meas
  import fpt_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic        start,
  input  wire logic        winEnd,
  input  wire logic        stepTick,
  input  wire logic        tach,
  input  wire logic [7:0]  glitch,
  output logic             active,
  output logic             stretch,
  output logic [7:0]       cycles,
  output logic [15:0]      ticks
);
  fpt_tach_state_t s_reg;
  fpt_tach_state_t s_next;
  logic            edgeSeen;

  always_comb begin
    s_next = s_reg;
    edgeSeen = s_reg.active && s_reg.primed && tach && !s_reg.prevTach && s_reg.glCnt == 8'h00;
    s_next.prevTach = tach;
    s_next.primed = s_reg.active;
    if (s_reg.active && stepTick && s_reg.glCnt != 8'h00) begin
      s_next.glCnt = s_reg.glCnt - 8'h01;
    end
    if (s_reg.running) begin
      s_next.div = s_reg.div + 5'h01;
      if (s_reg.div == `FPT_TICK_DIV && s_reg.tRun != 16'hFFFF) begin
        s_next.tRun = s_reg.tRun + 16'h0001;
      end
    end
    if (edgeSeen) begin
      s_next.running = 1'b1;
      s_next.ticks = s_reg.tRun;
      if (s_reg.edges != 8'hFF) begin
        s_next.edges = s_reg.edges + 8'h01;
      end
    end
    // Release once the glitch delay is over and two filtered edges were counted.
    if (s_reg.stretch && s_reg.glCnt == 8'h00 && s_reg.edges >= 8'h02) begin
      s_next.stretch = 1'b0;
    end
    if (winEnd) begin
      s_next.active = 1'b0;
      s_next.stretch = 1'b0;
    end
    if (start) begin
      s_next = '0;
      s_next.active = 1'b1;
      s_next.stretch = 1'b1;
      s_next.glCnt = glitch;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign active = s_reg.active;
  assign stretch = s_reg.stretch;
  assign cycles = s_reg.edges;
  assign ticks = s_reg.ticks;

  property p_hold;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && stretch && !winEnd && (s_reg.glCnt != 8'h00 || cycles < 8'h02) |=> stretch;
  endproperty
  a_hold: assert property (p_hold) else $error("Stretch released too early.");

  property p_max_stretch;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && winEnd && !start |=> !stretch;
  endproperty
  a_max_stretch: assert property (p_max_stretch) else $error("Stretch outlived window.");

  property p_saturate;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && !start && cycles == 8'hFF |=> cycles == 8'hFF;
  endproperty
  a_saturate: assert property (p_saturate) else $error("Tach count wrapped.");
endmodule
`default_nettype wire

/* File: logic/fpt_top.sv */
// Fan PWM and tachometer controller top: registers, timing, rotation, start-up, fail-safe.
// Assumes a 10 MHz ref_clk, synchronous tach inputs and a strobe register master.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "fpt_defs.svh"
// What this block does
// - Each of four fans has its own PWM output with duty from zero to full on.
// - Every fan PWM repeats at about 18 Hz and drives the fan's ground-side switch.
// - A fan's tach activity is counted over a window of one eighth of a second.
// - Fans are measured in a fixed rotation so each result refreshes every half second.
// - A fan enabled for reporting is forced fully on at the start of its window.
// - The force holds until the glitch delay has passed and two tach edges were seen.
// - A stretched on-pulse never lasts beyond one eighth of a second.
// - A fan with fail-safe enabled goes to full power when the host stops refreshing power.
// - At power-up each fan's power is full on or the saved boot value.
// - After power-up fans that are on start one at a time, half a second apart.
// - Each result carries fan index, tach cycles and a 16-bit tick count, high byte first.
module fpt_top
  import fpt_pkg::*;
#(
  parameter int STEP_CYC    = `FPT_CLK_HZ / (`FPT_PWM_FREQ_HZ * `FPT_DUTY_STEPS),
  parameter int WINDOW_CYC  = (`FPT_CLK_HZ / 1000) * `FPT_WINDOW_MS,
  parameter int STAGGER_CYC = (`FPT_CLK_HZ / 1000) * `FPT_STAGGER_MS
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  input  wire logic [3:0]  fanTach,
  input  wire logic        bootUseSaved,
  input  wire logic [27:0] bootPower,
  output logic [3:0]       fanGateOn,
  output logic             irq,
  output logic [7:0]       resultByte,
  output logic             resultByteValid,
  output logic             resultByteFirst
);
  fpt_top_state_t  s_reg;
  fpt_top_state_t  s_next;
  logic            stepTick;
  logic            winEnd;
  logic            fsExpired;
  logic            tachStart;
  logic            tachActive;
  logic            tachStretch;
  logic [7:0]      tachCycles;
  logic [15:0]     tachTicks;
  logic [3:0][6:0] effDuty;
  logic [3:0]      forceOn;
  logic [3:0]      fsActive;

  // Returns {hit, index} for a bank of four word registers starting at base.
  function automatic logic [2:0] bankSel(input logic [7:0] a, input logic [7:0] base);
    logic [7:0] d;
    d = a - base;
    bankSel = {(a >= base) && (d < 8'h10) && (d[1:0] == 2'b00), d[3:2]};
  endfunction

  // Values above full scale are clamped so the duty compare stays meaningful.
  function automatic logic [6:0] clampPct(input logic [31:0] v);
    clampPct = (v > 32'(`FPT_DUTY_FULL)) ? `FPT_DUTY_FULL : v[6:0];
  endfunction

  assign stepTick = (s_reg.stepCnt == 13'(STEP_CYC - 1));
  assign winEnd = (s_reg.winCnt == 21'(WINDOW_CYC - 1));
  assign fsExpired = (s_reg.fsTime != 8'h00) && (s_reg.fsCnt >= s_reg.fsTime);
  assign tachStart = winEnd && s_reg.ctrlRep[s_reg.measFan + 2'd1];

  always_comb begin
    for (int i = 0; i < `FPT_NUM_FANS; i++) begin
      fsActive[i] = s_reg.ctrlFs[i] && fsExpired;
      forceOn[i] = s_reg.started[i] && tachStretch && (s_reg.measFan == 2'(i));
      if (!s_reg.started[i]) begin
        effDuty[i] = 7'h00;
      end else if (fsActive[i]) begin
        effDuty[i] = `FPT_DUTY_FULL;
      end else begin
        effDuty[i] = s_reg.power[i];
      end
    end
  end

  always_comb begin
    logic [2:0] pSel;
    logic [2:0] rSel;
    logic [4:0] intSet;
    logic [4:0] intClr;
    s_next = s_reg;
    pSel = bankSel(regAddr, `FPT_OFS_POWER0);
    rSel = bankSel(regAddr, `FPT_OFS_RESULT0);
    intSet = '0;
    intClr = '0;

    // Shared duty phase: 100 steps per PWM period.
    s_next.stepCnt = stepTick ? 13'h0000 : s_reg.stepCnt + 13'h0001;
    if (stepTick) begin
      s_next.phase = (s_reg.phase == 7'(`FPT_DUTY_STEPS - 1)) ? 7'h00 : s_reg.phase + 7'h01;
    end

    // Window rotation over the four fans.
    s_next.winCnt = winEnd ? 21'h000000 : s_reg.winCnt + 21'h000001;
    if (winEnd) begin
      s_next.measFan = s_reg.measFan + 2'd1;
      if (s_reg.fsCnt != 8'hFF) begin
        s_next.fsCnt = s_reg.fsCnt + 8'h01;
      end
      if (tachActive) begin
        s_next.result[s_reg.measFan] = {tachCycles, tachTicks};
        s_next.byteSh = {6'h00, s_reg.measFan, tachCycles, tachTicks};
        s_next.byteCnt = 3'd4;
        intSet[s_reg.measFan] = 1'b1;
      end
    end
    if (s_next.fsCnt == s_reg.fsTime && s_reg.fsCnt != s_reg.fsTime && s_reg.fsTime != 8'h00
        && s_reg.ctrlFs != 4'h0) begin
      intSet[`FPT_INT_FS_BIT] = 1'b1;
    end

    // Result stream, one byte per cycle, index first and tick high byte before low byte.
    s_next.byteValid = 1'b0;
    s_next.byteFirst = 1'b0;
    if (s_reg.byteCnt != 3'd0) begin
      s_next.byteOut = s_reg.byteSh[31:24];
      s_next.byteValid = 1'b1;
      s_next.byteFirst = (s_reg.byteCnt == 3'd4);
      s_next.byteSh = {s_reg.byteSh[23:0], 8'h00};
      s_next.byteCnt = s_reg.byteCnt - 3'd1;
    end

    // Start-up: load power, then switch fans on one by one.
    case (s_reg.seq)
      FPT_LOAD: begin
        for (int i = 0; i < `FPT_NUM_FANS; i++) begin
          s_next.power[i] = bootUseSaved ? clampPct(32'(bootPower[7*i +: 7])) : `FPT_DUTY_FULL;
        end
        s_next.seq = FPT_STAGGER;
      end
      FPT_STAGGER: begin
        if (s_reg.gapCnt != 23'h000000) begin
          s_next.gapCnt = s_reg.gapCnt - 23'h000001;
        end else begin
          s_next.started[s_reg.startIdx] = 1'b1;
          if (s_reg.power[s_reg.startIdx] != 7'h00) begin
            s_next.gapCnt = 23'(STAGGER_CYC - 1);
          end
          s_next.startIdx = s_reg.startIdx + 2'd1;
          if (s_reg.startIdx == 2'd3) begin
            s_next.seq = FPT_RUN;
          end
        end
      end
      FPT_RUN: begin
        s_next.seq = FPT_RUN;
      end
      default: begin
        s_next.seq = FPT_LOAD;
      end
    endcase

    // Register writes.
    if (regWr) begin
      if (pSel[2]) begin
        s_next.power[pSel[1:0]] = clampPct(regWdata);
        s_next.fsCnt = 8'h00;
      end
      case (regAddr)
        `FPT_OFS_CTRL: begin
          s_next.ctrlRep = regWdata[`FPT_CTRL_REP_LSB +: 4];
          s_next.ctrlFs = regWdata[`FPT_CTRL_FS_LSB +: 4];
        end
        `FPT_OFS_FSTIME: s_next.fsTime = regWdata[7:0];
        `FPT_OFS_GLITCH: s_next.glitch = regWdata[7:0];
        `FPT_OFS_INTSTAT: intClr = regWdata[4:0];
        `FPT_OFS_INTMASK: s_next.intMask = regWdata[4:0];
        default: begin
        end
      endcase
    end
    // A new event in the clearing cycle survives the clear.
    s_next.intStat = (s_reg.intStat & ~intClr) | intSet;

    // Register reads: data stand in the cycle after the strobe only.
    s_next.rdata = 32'h00000000;
    if (regRd) begin
      if (pSel[2]) begin
        s_next.rdata = {25'h0000000, s_reg.power[pSel[1:0]]};
      end else if (rSel[2]) begin
        s_next.rdata = {8'h00, s_reg.result[rSel[1:0]]};
      end else begin
        case (regAddr)
          `FPT_OFS_CTRL: s_next.rdata = {24'h000000, s_reg.ctrlFs, s_reg.ctrlRep};
          `FPT_OFS_FSTIME: s_next.rdata = {24'h000000, s_reg.fsTime};
          `FPT_OFS_GLITCH: s_next.rdata = {24'h000000, s_reg.glitch};
          `FPT_OFS_INTSTAT: s_next.rdata = {27'h0000000, s_reg.intStat};
          `FPT_OFS_INTMASK: s_next.rdata = {27'h0000000, s_reg.intMask};
          `FPT_OFS_STATUS: s_next.rdata = {18'h00000, tachStretch, tachActive, s_reg.measFan,
                                           fsActive, s_reg.started};
          default: s_next.rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg <= '0;
      s_reg.ctrlRep <= 4'(`FPT_RST_CTRL);
      s_reg.ctrlFs <= 4'(`FPT_RST_CTRL >> `FPT_CTRL_FS_LSB);
      s_reg.fsTime <= `FPT_RST_FSTIME;
      s_reg.glitch <= `FPT_RST_GLITCH;
      s_reg.intMask <= `FPT_RST_INTMASK;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  fpt_tach_meas u_fpt_tach_meas (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .ce       (ce),
    .start    (tachStart),
    .winEnd   (winEnd),
    .stepTick (stepTick),
    .tach     (fanTach[s_reg.measFan]),
    .glitch   (s_reg.glitch),
    .active   (tachActive),
    .stretch  (tachStretch),
    .cycles   (tachCycles),
    .ticks    (tachTicks)
  );

  genvar gi;
  generate
    for (gi = 0; gi < `FPT_NUM_FANS; gi++) begin : g_chan
      fpt_pwm_chan u_fpt_pwm_chan (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .ce       (ce),
        .duty     (effDuty[gi]),
        .phase    (s_reg.phase),
        .force_on (forceOn[gi]),
        .gateOn   (fanGateOn[gi])
      );
    end
  endgenerate

  assign regRdata = s_reg.rdata;
  assign irq = |(s_reg.intStat & s_reg.intMask);
  assign resultByte = s_reg.byteOut;
  assign resultByteValid = s_reg.byteValid;
  assign resultByteFirst = s_reg.byteFirst;

  property p_phase_range;
    @(posedge ref_clk) disable iff (!rst_b)
      s_reg.phase < 7'(`FPT_DUTY_STEPS) && s_reg.stepCnt < 13'(STEP_CYC);
  endproperty
  a_phase_range: assert property (p_phase_range) else $error("PWM phase out of range.");

  property p_window;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && winEnd |=> s_reg.winCnt == 21'h000000 && s_reg.measFan == $past(s_reg.measFan) + 2'd1;
  endproperty
  a_window: assert property (p_window) else $error("Window rotation broken.");

  property p_start_force;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && tachStart |=> tachStretch && tachActive;
  endproperty
  a_start_force: assert property (p_start_force) else $error("Window start did not force.");

  property p_failsafe;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && s_reg.started[0] && s_reg.ctrlFs[0] && fsExpired |=> fanGateOn[0];
  endproperty
  a_failsafe: assert property (p_failsafe) else $error("Fail-safe did not force full power.");

  property p_stagger;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && s_reg.gapCnt != 23'h000000 |=> s_reg.started == $past(s_reg.started);
  endproperty
  a_stagger: assert property (p_stagger) else $error("Fan started inside the gap.");

  property p_pct;
    @(posedge ref_clk) disable iff (!rst_b)
      s_reg.power[0] <= `FPT_DUTY_FULL && s_reg.power[3] <= `FPT_DUTY_FULL;
  endproperty
  a_pct: assert property (p_pct) else $error("Power above full scale.");

  property p_stream;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && winEnd && tachActive ##1 ce [*2] |-> resultByteFirst
        && resultByte == {6'h00, $past(s_reg.measFan, 2)};
  endproperty
  a_stream: assert property (p_stream) else $error("Result stream out of order.");

  property p_load;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && s_reg.seq == FPT_LOAD && !bootUseSaved |=> s_reg.power[1] == `FPT_DUTY_FULL;
  endproperty
  a_load: assert property (p_load) else $error("Default power not full on.");

  property p_freeze;
    @(posedge ref_clk) disable iff (!rst_b)
      !ce |=> $stable(s_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved with ce low.");

  property p_idle_off;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && !s_reg.started[1] |=> !fanGateOn[1];
  endproperty
  a_idle_off: assert property (p_idle_off) else $error("Fan on before start.");

  property p_full_on;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && s_reg.started[2] && s_reg.power[2] == `FPT_DUTY_FULL |=> fanGateOn[2];
  endproperty
  a_full_on: assert property (p_full_on) else $error("Full power fan off.");

  property p_tick;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && stepTick |=> s_reg.stepCnt == 13'h0000;
  endproperty
  a_tick: assert property (p_tick) else $error("Step counter missed wrap.");

  property p_no_force;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && winEnd && !tachStart |=> !tachStretch;
  endproperty
  a_no_force: assert property (p_no_force) else $error("Unreported fan forced.");

  property p_queue;
    @(posedge ref_clk) disable iff (!rst_b)
      ce && winEnd && tachActive |=> s_reg.byteCnt == 3'd4;
  endproperty
  a_queue: assert property (p_queue) else $error("Result not queued.");
endmodule
`default_nettype wire

/* File: tb/fpt_fan_model.sv */
// Behavioural three-wire fan: the tach output toggles at a fixed rate while the fan is powered and not dead.
// Assumes the gate input is high while the fan's ground switch is on.
`timescale 1ns/1ns
`default_nettype none
module fpt_fan_model #(
  parameter int HALF = 50
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic powered,
  input  wire logic dead,
  output logic      tach
);
  int cnt;
  // A stopped rotor leaves the hall sensor where it was, so tach holds its level.
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 0;
      tach <= 1'b0;
    end else if (powered && !dead) begin
      if (cnt >= HALF - 1) begin
        cnt <= 0;
        tach <= ~tach;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/fpt_top_bench.sv */
// Self-checking bench of the fan controller: start-up, PWM, tach windows, fail-safe.
// Assumes the design files are compiled first; fan models answer on the tach inputs.
`timescale 1ns/1ns
`default_nettype none
module fpt_top_bench
  import fpt_pkg::*;
;
  localparam int STEP = 10;
  localparam int WIN = 2000;
  localparam int STAG = 300;
  localparam int LIMIT = 80000;
  localparam int DUTY [6] = '{0, 1, 30, 99, 100, 120};
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [31:0] regRdata;
  wire  [3:0]  fanTach;
  logic        bootUseSaved = 1'b0;
  logic [27:0] bootPower = 28'h0;
  logic [3:0]  fanGateOn;
  logic        irq;
  logic [7:0]  resultByte;
  logic        resultByteValid;
  logic        resultByteFirst;
  logic [3:0]  fanDead = 4'h0;
  int          errCount = 0;
  int          nChecks = 0;
  int          cyc = 0;
  int          pos = 0;
  int          riseAt [4];
  int          maxOn [4] = '{0, 0, 0, 0};
  int          onRun [4] = '{0, 0, 0, 0};
  logic [31:0] res [$];
  int          resAt [$];
  logic [31:0] acc = 32'h0;
  logic [31:0] rv;

  always #50 ref_clk = ~ref_clk;

  fpt_top #(.STEP_CYC(STEP), .WINDOW_CYC(WIN), .STAGGER_CYC(STAG)) u_fpt_top (
    .ref_clk(ref_clk), .rst_b(rst_b), .ce(ce), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .fanTach(fanTach),
    .bootUseSaved(bootUseSaved), .bootPower(bootPower), .fanGateOn(fanGateOn), .irq(irq),
    .resultByte(resultByte), .resultByteValid(resultByteValid),
    .resultByteFirst(resultByteFirst));

  // Fan 3 toggles every cycle so that its edge count must saturate.
  for (genvar i = 0; i < 4; i++) begin : g_fan
    fpt_fan_model #(.HALF(i == 3 ? 1 : 50)) u_fpt_fan_model (
      .ref_clk(ref_clk), .rst_b(rst_b), .powered(fanGateOn[i]), .dead(fanDead[i]),
      .tach(fanTach[i]));
  end

  always @(posedge ref_clk) begin
    if (cyc == LIMIT) begin
      errCount++;
      $display("[ERR] run time expected below %0d cycles seen %0d", LIMIT, cyc);
      end_of_test();
    end
  end

  always @(posedge ref_clk) begin
    cyc++;
    for (int i = 0; i < 4; i++) begin
      if (fanGateOn[i] === 1'b1) begin
        onRun[i]++;
        if (riseAt[i] < 0) riseAt[i] = cyc;
        if (onRun[i] > maxOn[i]) maxOn[i] = onRun[i];
      end else begin
        onRun[i] = 0;
      end
    end
    if (resultByteValid === 1'b1) begin
      pos = (resultByteFirst === 1'b1) ? 0 : pos + 1;
      acc = {acc[23:0], resultByte};
      if (pos == 3) begin
        res.push_back(acc);
        resAt.push_back(cyc);
      end
    end
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask

  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp,
                      input logic [31:0] m = 32'hFFFFFFFF);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    rv = regRdata & m;
    chk(name, rv, exp);
  endtask

  task automatic meas(input int f, input int n, output int on, output int rises);
    logic prev;
    on = 0;
    rises = 0;
    @(posedge ref_clk);
    #1;
    prev = fanGateOn[f];
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      if (fanGateOn[f] === 1'b1) on++;
      if (fanGateOn[f] === 1'b1 && prev === 1'b0) rises++;
      prev = fanGateOn[f];
    end
  endtask

  task automatic doReset(input logic saved, input logic [27:0] pw);
    @(posedge ref_clk);
    rst_b <= 1'b0;
    bootUseSaved <= saved;
    bootPower <= pw;
    repeat (2) @(posedge ref_clk);
    for (int i = 0; i < 4; i++) riseAt[i] = -1;
    repeat (6) @(posedge ref_clk);
    rst_b <= 1'b1;
  endtask

  task automatic startChk(input int pw [4]);
    int prev;
    prev = -1;
    repeat (4 * STAG + 100) @(posedge ref_clk);
    rchk("status", 8'h34, 32'h0000000F);
    for (int i = 0; i < 4; i++) begin
      rchk("boot power", 8'h04 + 8'(4 * i), 32'(pw[i]));
      if (pw[i] == 0) begin
        chk("idle fan rise", 32'(riseAt[i]), 32'hFFFFFFFF);
      end else begin
        if (prev >= 0) chk("gap", 32'(riseAt[i] - prev >= STAG && riseAt[i] - prev <= STAG + 2), 1);
        prev = riseAt[i];
      end
    end
  endtask

  // One tick is 32 clock cycles; the count spans first to last counted edge.
  function automatic logic tickOk(input logic [31:0] r, input int per);
    int e;
    e = (int'(r[23:16]) - 1) * per / 32;
    return int'(r[15:0]) >= e - 1 && int'(r[15:0]) <= e + 1;
  endfunction

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", nChecks, errCount);
    if (errCount == 0 && nChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    int on;
    int rises;
    int d;
    logic [31:0] r;
    doReset(1'b0, 28'h0);
    rchk("ctrl reset", 8'h00, 32'h0);
    rchk("fail-safe interval reset", 8'h14, 32'h10);
    rchk("glitch reset", 8'h18, 32'h01);
    rchk("unmapped read", 8'h3C, 32'h0);
    startChk('{100, 100, 100, 100});
    doReset(1'b1, {7'h64, 7'h78, 7'h00, 7'h64});
    startChk('{100, 0, 100, 100});
    $display("test reset and start-up done");
    for (int k = 0; k < 6; k++) begin
      d = DUTY[k] > 100 ? 100 : DUTY[k];
      wr(8'h04, 32'(DUTY[k]));
      rchk("power readback", 8'h04, 32'(d));
      meas(0, 200 * STEP, on, rises);
      chk("pwm on cycles", 32'(on), 32'(2 * d * STEP));
      chk("pwm periods", 32'(rises), (d == 0 || d == 100) ? 32'h0 : 32'h2);
    end
    $display("test pwm done");
    wr(8'h04, 32'h64);
    wr(8'h08, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h10, 32'h64);
    fanDead <= 4'h4;
    wr(8'h00, 32'h0F);
    repeat (2 * WIN) @(posedge ref_clk);
    res.delete();
    resAt.delete();
    for (int i = 0; i < 4; i++) maxOn[i] = 0;
    for (int t = 0; t < 6 * WIN && res.size() < 5; t++) @(posedge ref_clk);
    chk("result count", 32'(res.size() >= 5), 1);
    for (int k = 0; k < 5 && k < res.size(); k++) begin
      r = res[k];
      if (k > 0) begin
        chk("fan rotation", {24'h0, r[31:24]}, {24'h0, (res[k-1][31:24] + 8'h01) & 8'h03});
        chk("window spacing", 32'(resAt[k] - resAt[k-1]), 32'(WIN));
      end
      case (r[31:24])
        8'h00: chk("steady fan", 32'(r[23:16] >= 8'h12 && r[23:16] <= 8'h14 && tickOk(r, 100)), 1);
        8'h01: chk("stretched fan", 32'(r[23:16] >= 8'h02 && r[23:16] <= 8'h03 && tickOk(r, 100)), 1);
        8'h02: chk("dead fan cycles", {24'h0, r[23:16]}, 32'h0);
        default: chk("fast fan cycles", {24'h0, r[23:16]}, 32'hFF);
      endcase
    end
    chk("stretch ends", 32'(maxOn[1] >= 2 && maxOn[1] < 400), 1);
    chk("stretch limit", 32'(maxOn[2] >= WIN - 3 && maxOn[2] <= WIN), 1);
    rchk("results ready", 8'h1C, 32'h0F);
    $display("test tach done");
    wr(8'h00, 32'h0);
    repeat (WIN) @(posedge ref_clk);
    wr(8'h1C, 32'h1F);
    wr(8'h20, 32'h10);
    wr(8'h14, 32'h02);
    wr(8'h00, 32'h10);
    wr(8'h04, 32'h0);
    #1;
    chk("irq idle", {31'h0, irq}, 32'h0);
    for (int t = 0; t < 4 * WIN && irq !== 1'b1; t++) @(posedge ref_clk);
    meas(0, 100 * STEP, on, rises);
    chk("fail-safe full power", 32'(on), 32'(100 * STEP));
    meas(1, 100 * STEP, on, rises);
    chk("unguarded fan off", 32'(on), 32'h0);
    rchk("fail-safe status", 8'h34, 32'h0000001F, 32'hFFFFFCFF);
    rchk("fail-safe event", 8'h1C, 32'h10);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(8'h20, 32'h0);
    rchk("mask cleared", 8'h20, 32'h0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(8'h20, 32'h10);
    wr(8'h1C, 32'h10);
    rchk("event cleared", 8'h1C, 32'h0);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(8'h04, 32'h0);
    meas(0, 100 * STEP, on, rises);
    chk("refresh restores power", 32'(on), 32'h0);
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'h04, 32'h32);
    ce <= 1'b1;
    rchk("frozen write", 8'h04, 32'h0);
    $display("test fail-safe done");
    end_of_test();
  end
endmodule
`default_nettype wire
